// >>> rtl/ssi_consts.svh
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH
`define SSI_REG_OPCOND 16'h0262
`define SSI_REG_TEMP_LO 16'h03ea
`define SSI_REG_TEMP_HI 16'h03eb
`define SSI_SLAVE_ADDR 8'he6
`define SSI_NAN32 32'h7fc00000
`define SSI_NAN_INT16 16'h8000
`define SSI_BIT_PCB_LOW 0
`define SSI_BIT_PCB_HIGH 1
`define SSI_BIT_T_LOW 2
`define SSI_BIT_T_HIGH 3
`define SSI_BIT_AUX_LOW 4
`define SSI_BIT_AUX_HIGH 5
`define SSI_BIT_RH_DRY 6
`define SSI_BIT_RH_COND 7
`define SSI_BEEP_PERIOD_S 10
`define SSI_BLINK_PERIOD_MS 500
`define SSI_CLK_HZ 250000000
`define SSI_BEEP_CYCLES (`SSI_BEEP_PERIOD_S * 32'd250000000)
`define SSI_BLINK_CYCLES (`SSI_BLINK_PERIOD_MS * 32'd250000)
`define SSI_HEAT_MS 1000
`define SSI_HEAT_CYCLES (`SSI_HEAT_MS * 32'd250000)
`endif

// >>> rtl/ssi_pkg.sv
package ssi_pkg;
  typedef struct packed {
    logic pcb_low;
    logic pcb_high;
    logic t_low;
    logic t_high;
    logic aux_low;
    logic aux_high;
    logic rh_dry;
    logic rh_cond;
  } ssi_events_s;
  typedef struct packed {
    logic vout1_short;
    logic iout1_open;
    logic rh_polluted;
    logic hw_fault;
    logic t_fail;
    logic rh_fail;
  } ssi_faults_s;
  typedef struct packed {
    logic blue;
    logic orange;
    logic green;
    logic red;
    logic recovery;
  } ssi_leds_s;
  typedef enum logic [1:0] {
    SSI_CAT_NONE,
    SSI_CAT_ONE,
    SSI_CAT_TWO
  } ssi_cat_e;
  typedef enum logic [3:0] {
    SSI_CODE_NONE = 4'h0,
    SSI_CODE_1 = 4'h1,
    SSI_CODE_2 = 4'h2,
    SSI_CODE_3 = 4'h3,
    SSI_CODE_5 = 4'h5,
    SSI_CODE_7 = 4'h7,
    SSI_CODE_10 = 4'ha
  } ssi_code_e;
  typedef enum {SSI_IDLE, SSI_HEAT} ssi_heat_e;
endpackage

// >>> rtl/ssi_status.sv
// Behaviour
// R1: critical error forces nan or 8000 reads
// R2: event flags readable at register 0x262
// R3: one bit per event, 1 while present
// R4: out-of-range temperature clamped to limits
// R5: bits 0 and 1 board temperature limits
// R6: bits 2-5 process and auxiliary temperature
// R7: bits 6 and 7 dry and condensation
// R8: bits 8 to 15 read zero
// R9: answers slave address 230 unless reconfigured
// R10: temperature float at registers 0x3ea, 0x3eb
// R11: low mantissa word first, high byte first
// R12: codes 1, 2, 3 are category one
// R13: codes 5 to 10 are category two
// R14: category one blinks, beeps every 10 s
// R15: category one red indicator steady
// R16: category two continuous beep, red flashes
// R17: blue for voltage, orange for current
// R18: green flashes while supply and cpu run
// R19: expansion module probed and enabled at power-on
// R20: trigger starts brief intense heating cycle
// R21: fifth indicator lit during recovery heating
`timescale 1ns/100ps
`include "ssi_consts.svh"
module ssi_status
  import ssi_pkg::*;
#(
  parameter logic [31:0] TEMP_MIN = 32'hc2200000,
  parameter logic [31:0] TEMP_MAX = 32'h43200000,
  // unsigned: the beep period count does not fit a signed int
  parameter int unsigned BEEP_CYCLES = `SSI_BEEP_CYCLES,
  parameter int unsigned BLINK_CYCLES = `SSI_BLINK_CYCLES,
  parameter int unsigned HEAT_CYCLES = `SSI_HEAT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // measurement and conditions
  input wire ssi_events_s events,
  input wire logic [31:0] temp_raw,
  input wire ssi_faults_s faults,
  // configuration
  input wire logic addr_override,
  input wire logic [7:0] addr_cfg,
  input wire logic out1_is_voltage,
  input wire logic cpu_running,
  // register access
  input wire logic rd_req,
  input wire logic [7:0] rd_slave,
  input wire logic [15:0] rd_addr,
  output logic rd_ack,
  output logic rd_hit,
  output logic [15:0] rd_data,
  // expansion module
  input wire logic module_present,
  output logic module_enable,
  // recovery heating
  input wire logic heat_trigger,
  output logic heat_on,
  // local indication
  output ssi_cat_e category,
  output ssi_code_e disp_code,
  output logic disp_blink,
  output logic buzzer,
  output ssi_leds_s leds
);
  // float compare of ordered ieee values
  function automatic logic flt_lt(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31])
      flt_lt = a[31] && (a[30:0] != 31'h0 || b[30:0] != 31'h0);
    else if (a[31])
      flt_lt = a[30:0] > b[30:0];
    else
      flt_lt = a[30:0] < b[30:0];
  endfunction

  logic [31:0] temp_clamped;
  logic [31:0] temp_float;
  logic [15:0] opcond_word;
  logic critical;
  logic cat1;
  logic [7:0] my_addr;
  logic addr_match;
  logic sel_opcond;
  logic sel_lo;
  logic sel_hi;
  logic [15:0] next_rd_data;
  logic [31:0] beep_cnt;
  logic [31:0] blink_cnt;
  logic [31:0] heat_cnt;
  logic blink_ph;
  logic beep_tick;
  logic probed;
  logic trig_d;
  ssi_heat_e heat_st;

  assign temp_clamped = flt_lt(temp_raw, TEMP_MIN) ? TEMP_MIN :
                        flt_lt(TEMP_MAX, temp_raw) ? TEMP_MAX :
                        temp_raw; // R4
  assign critical = faults.hw_fault | faults.t_fail | faults.rh_fail; // R13
  assign cat1 = faults.vout1_short | faults.iout1_open |
                faults.rh_polluted; // R12
  assign temp_float = critical ? `SSI_NAN32 : temp_clamped; // R1
  assign opcond_word = {8'h00, // R8
                        events.rh_cond, events.rh_dry, // R7
                        events.aux_high, events.aux_low,
                        events.t_high, events.t_low, // R6
                        events.pcb_high, events.pcb_low}; // R5 R3
  assign my_addr = addr_override ? addr_cfg : `SSI_SLAVE_ADDR; // R9
  assign addr_match = rd_slave == my_addr; // R9
  assign sel_opcond = rd_addr == `SSI_REG_OPCOND; // R2
  assign sel_lo = rd_addr == `SSI_REG_TEMP_LO; // R10
  assign sel_hi = rd_addr == `SSI_REG_TEMP_HI; // R10
  // opcond stays readable; the integer marker 8000 answers every register
  // other than 0x262, 0x3ea and 0x3eb, whether or not an error is critical
  assign next_rd_data = sel_opcond ? opcond_word :
                        sel_lo ? temp_float[15:0] : // R11
                        sel_hi ? temp_float[31:16] : // R11
                        `SSI_NAN_INT16; // R1

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack <= 1'b0;
      rd_hit <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_ack <= rd_req & addr_match;
      rd_hit <= rd_req & addr_match & (sel_opcond | sel_lo | sel_hi);
      if (rd_req && addr_match) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // category and display code
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      category <= SSI_CAT_NONE;
      disp_code <= SSI_CODE_NONE;
    end else begin
      category <= critical ? SSI_CAT_TWO :
                  cat1 ? SSI_CAT_ONE : SSI_CAT_NONE; // R12 R13
      disp_code <= faults.hw_fault ? SSI_CODE_5 :
                   faults.t_fail ? SSI_CODE_7 :
                   faults.rh_fail ? SSI_CODE_10 :
                   faults.vout1_short ? SSI_CODE_1 :
                   faults.iout1_open ? SSI_CODE_2 :
                   faults.rh_polluted ? SSI_CODE_3 :
                   SSI_CODE_NONE; // R12 R13
    end
  end

  // blink phase and beep period
  assign beep_tick = beep_cnt == 32'(BEEP_CYCLES - 1);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= 32'h0;
      blink_ph <= 1'b0;
      beep_cnt <= 32'h0;
    end else begin
      blink_cnt <= (blink_cnt == 32'(BLINK_CYCLES - 1)) ? 32'h0 :
                   blink_cnt + 32'h1;
      if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
        blink_ph <= ~blink_ph;
      end
      beep_cnt <= beep_tick ? 32'h0 : beep_cnt + 32'h1; // R14
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_blink <= 1'b0;
      buzzer <= 1'b0;
      leds <= '0;
    end else begin
      disp_blink <= (critical | cat1) & blink_ph; // R14 R16
      buzzer <= critical | (cat1 & beep_tick); // R14 R16
      leds.red <= critical ? blink_ph : cat1; // R15 R16
      leds.blue <= out1_is_voltage; // R17
      leds.orange <= ~out1_is_voltage; // R17
      leds.green <= cpu_running & blink_ph; // R18
      leds.recovery <= heat_st == SSI_HEAT; // R21
    end
  end

  // expansion module probe after reset release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      probed <= 1'b0;
      module_enable <= 1'b0;
    end else if (!probed) begin
      probed <= 1'b1;
      module_enable <= module_present; // R19
    end
  end

  // recovery heating on trigger rising edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_d <= 1'b0;
      heat_st <= SSI_IDLE;
      heat_cnt <= 32'h0;
    end else begin
      trig_d <= heat_trigger;
      unique case (heat_st)
        SSI_IDLE: begin
          if (heat_trigger && !trig_d) begin
            heat_st <= SSI_HEAT; // R20
            heat_cnt <= 32'h0;
          end
        end
        SSI_HEAT: begin
          heat_cnt <= heat_cnt + 32'h1;
          if (heat_cnt == 32'(HEAT_CYCLES - 1)) begin
            heat_st <= SSI_IDLE; // R20
          end
        end
      endcase
    end
  end
  assign heat_on = heat_st == SSI_HEAT; // R20
endmodule

// >>> tb/ssi_monitor.sv
`timescale 1ns/100ps
module ssi_monitor
  import ssi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // inputs
  input wire ssi_events_s events,
  input wire ssi_faults_s faults,
  input wire logic addr_override,
  input wire logic heat_trigger,
  input wire logic rd_req,
  input wire logic [7:0] rd_slave,
  input wire logic [15:0] rd_addr,
  // outputs
  input wire logic rd_ack,
  input wire logic rd_hit,
  input wire logic [15:0] rd_data,
  input wire logic heat_on,
  input wire logic buzzer,
  input wire ssi_cat_e category,
  input wire ssi_leds_s leds
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] ev = {events.rh_cond, events.rh_dry, events.aux_high,
    events.aux_low, events.t_high, events.t_low, events.pcb_high,
    events.pcb_low};
  wire logic crit = faults.hw_fault | faults.t_fail | faults.rh_fail;
  wire logic me = rd_req && !addr_override;
  wire logic req = me && rd_slave == 8'he6;
  a_read_answers: assert property (req |=> rd_ack)
    else $error("no ack");
  a_foreign_quiet: assert property (me && !req |=> !rd_ack)
    else $error("foreign ack");
  a_opcond_word: assert property (req && rd_addr == 16'h0262
    |=> rd_hit && rd_data == {8'h00, $past(ev)}) else $error("opcond");
  a_crit_nan: assert property (req && crit && rd_addr == 16'h03eb
    |=> rd_data == 16'h7fc0) else $error("no nan");
  a_unmapped_miss: assert property (req && rd_addr != 16'h0262
    && rd_addr != 16'h03ea && rd_addr != 16'h03eb
    |=> rd_ack && !rd_hit && rd_data == 16'h8000) else $error("unmapped");
  a_cat_two_tone: assert property ($past(category) == SSI_CAT_TWO
    && category == SSI_CAT_TWO |-> buzzer) else $error("no tone");
  a_cat_one_red: assert property ($past(category) == SSI_CAT_ONE
    && category == SSI_CAT_ONE |-> leds.red) else $error("red off");
  a_heat_span: assert property ($rose(heat_trigger) && !heat_on
    |=> heat_on ##9 heat_on ##1 !heat_on) else $error("heat span");
  a_recovery_led: assert property (leds.recovery == $past(heat_on))
    else $error("recovery led");
  cover property (req && rd_addr == 16'h03ea);
  cover property (category == SSI_CAT_ONE && buzzer);
  cover property (heat_on ##1 !heat_on);
  cover property (rd_ack && !rd_hit);
endmodule
bind ssi_status ssi_monitor ssi_monitor_i (.ref_clk, .rst_b, .events,
  .faults, .addr_override, .heat_trigger, .rd_req, .rd_slave, .rd_addr,
  .rd_ack, .rd_hit, .rd_data, .heat_on, .buzzer, .category, .leds);

// >>> tb/ssi_master.sv
`timescale 1ns/100ps
module ssi_master (
  // clock
  input wire logic ref_clk,
  // request
  output logic rd_req = 1'b0,
  output logic [7:0] rd_slave = 8'h00,
  output logic [15:0] rd_addr = 16'h0000,
  // answer
  input wire logic rd_ack,
  input wire logic [15:0] rd_data
);
  // one-edge request pulse, answer sampled one edge later
  task automatic read(input logic [7:0] s, input logic [15:0] a,
    output logic k, output logic [15:0] d);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_slave <= s;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    rd_slave <= ~s;
    rd_addr <= ~a;
    @(posedge ref_clk);
    k = rd_ack;
    d = rd_data;
  endtask
endmodule

// >>> tb/test_sensor_status_indication.sv
`timescale 1ns/100ps
module test_sensor_status_indication
  import ssi_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ssi_events_s events = '0;
  ssi_faults_s faults = '0;
  logic [31:0] temp_raw = '0;
  logic addr_override = 1'b0;
  logic heat_trigger = 1'b0;
  logic out1_is_voltage = 1'b1;
  logic cpu_running = 1'b1;
  logic module_present = 1'b1;
  logic rd_req, rd_ack, rd_hit, module_enable, heat_on, buzzer, disp_blink;
  logic [7:0] rd_slave;
  logic [15:0] rd_addr, rd_data;
  ssi_cat_e category;
  ssi_code_e disp_code;
  ssi_leds_s leds;
  int error_cnt = 0;
  int comparisons = 0;
  int n, m, b;
  ssi_status #(.BEEP_CYCLES(40), .BLINK_CYCLES(4), .HEAT_CYCLES(10))
    ssi_status_i (.ref_clk, .rst_b, .events, .temp_raw, .faults,
    .addr_override, .addr_cfg(8'h11), .out1_is_voltage, .cpu_running,
    .rd_req, .rd_slave, .rd_addr, .rd_ack, .rd_hit, .rd_data,
    .module_present, .module_enable, .heat_trigger, .heat_on, .category,
    .disp_code, .disp_blink, .buzzer, .leds);
  ssi_master ssi_master_i (.ref_clk, .rd_req, .rd_slave, .rd_addr,
    .rd_ack, .rd_data);
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #8000;
    error_cnt++;
    finish_test();
  end
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    comparisons++;
    if (v !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic rd(logic [7:0] s, logic [15:0] a, logic ea, logic [15:0] e);
    logic k;
    logic [15:0] d;
    ssi_master_i.read(s, a, k, d);
    chk("ack", ea, k);
    if (ea) chk("data", e, d);
  endtask
  task automatic t_regs();
    events <= 8'hca;
    rd(8'he6, 16'h0262, 1, 16'h0053);
    temp_raw <= 32'h41cd6dfb;
    rd(8'he6, 16'h03ea, 1, 16'h6dfb);
    rd(8'he6, 16'h03eb, 1, 16'h41cd);
    temp_raw <= 32'h43c80000;
    rd(8'he6, 16'h03eb, 1, 16'h4320);
    rd(8'he6, 16'h0100, 1, 16'h8000);
    rd(8'h11, 16'h0262, 0, 16'h0);
    addr_override <= 1'b1;
    rd(8'h11, 16'h0262, 1, 16'h0053);
    addr_override <= 1'b0;
  endtask
  task automatic t_faults();
    ssi_code_e codes[6] = '{SSI_CODE_1, SSI_CODE_2, SSI_CODE_3,
      SSI_CODE_5, SSI_CODE_7, SSI_CODE_10};
    for (int i = 0; i < 6; i++) begin
      faults <= 6'h20 >> i;
      repeat (3) @(posedge ref_clk);
      chk("cat", i < 3 ? SSI_CAT_ONE : SSI_CAT_TWO, category);
      chk("code", codes[i], disp_code);
      if (i < 3) chk("red", 1, leds.red);
      n = 0;
      m = 0;
      b = 0;
      repeat (40) begin
        @(posedge ref_clk);
        n += (buzzer === 1'b1);
        m += (leds.red === 1'b1);
        b += (disp_blink === 1'b1);
      end
      chk("beeps", i < 3 ? 1 : 40, n);
      chk("red", i < 3 ? 40 : 20, m);
      chk("blink", 20, b);
      if (i == 4) rd(8'he6, 16'h03eb, 1, 16'h7fc0);
    end
    faults <= '0;
  endtask
  task automatic t_heat();
    heat_trigger <= 1'b1;
    n = 0;
    repeat (15) begin
      @(posedge ref_clk);
      n += (heat_on === 1'b1);
    end
    chk("heat", 10, n);
    heat_trigger <= 1'b0;
  endtask
  task automatic t_leds();
    for (int v = 0; v < 2; v++) begin
      out1_is_voltage <= v[0];
      cpu_running <= v[0];
      repeat (2) @(posedge ref_clk);
      chk("blue", v, leds.blue);
      chk("orange", 1 - v, leds.orange);
      n = 0;
      repeat (16) begin
        @(posedge ref_clk);
        n += (leds.green === 1'b1);
      end
      chk("green", v * 8, n);
    end
  endtask
  task automatic t_probe();
    for (int p = 0; p < 2; p++) begin
      rst_b <= 1'b0;
      module_present <= p[0];
      repeat (2) @(posedge ref_clk);
      chk("enable", 0, module_enable);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      module_present <= ~p[0];
      repeat (2) @(posedge ref_clk);
      chk("enable", p, module_enable);
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    chk("enable", 1, module_enable);
    chk("blue", 1, leds.blue);
    t_leds();
    t_faults();
    t_heat();
    t_probe();
    finish_test();
  end
endmodule
